// ### pkg/beg_pkg.sv
// Purpose: Shared constants for the bridge extra general-purpose pin block
// Assumes: 32-bit AXI4-Lite register access, byte addresses
// Notes:   Field positions are low bit plus width; all fields reset to zero
package beg_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned BEG_ADDR_W = 12;
  localparam logic [11:0] BEG_OFF_EXT = 12'h300;
  localparam logic [11:0] BEG_OFF_XTR = 12'h304;
  localparam logic [31:0] BEG_RESET_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Field layout, extended pin register
  // ----------------------------------------------------------------
  localparam int unsigned BEG_EXT_N = 3;
  localparam int unsigned BEG_EXT_VCLR_LSB = 0;
  localparam int unsigned BEG_EXT_VSET_LSB = 3;
  localparam int unsigned BEG_EXT_ECLR_LSB = 6;
  localparam int unsigned BEG_EXT_ESET_LSB = 9;
  localparam int unsigned BEG_EXT_IN_LSB = 12;

  // ----------------------------------------------------------------
  // Field layout, extra output and input register
  // ----------------------------------------------------------------
  localparam int unsigned BEG_XTR_N = 4;
  localparam int unsigned BEG_XTR_VCLR_LSB = 0;
  localparam int unsigned BEG_XTR_VSET_LSB = 4;
  localparam int unsigned BEG_XTR_ECLR_LSB = 8;
  localparam int unsigned BEG_XTR_ESET_LSB = 12;
  localparam int unsigned BEG_XTR_IN_LSB = 16;

  // AXI responses
  localparam logic [1:0] BEG_RESP_OKAY = 2'h0;
  localparam logic [1:0] BEG_RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    BEG_IDLE = 1'b0,
    BEG_RESP = 1'b1
  } beg_chan_t;
endpackage

// ### pkg/beg_wr_if.sv
// Purpose: Carries one decoded register write between the bus slave and pin banks
// Assumes: Single clock domain
// Notes:   Strobes are one-cycle pulses
`timescale 1ns/1ps
interface beg_wr_if;
  logic wr_ext;
  logic wr_xtr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  modport src (output wr_ext, output wr_xtr, output wdata, output wstrb);
  modport dst (input wr_ext, input wr_xtr, input wdata, input wstrb);
endinterface

// ### hdl/beg_axil_slave.sv
// Purpose: AXI4-Lite slave front end that decodes writes for the pin banks
// Assumes: One write and one read at most outstanding
// Notes:   Read data is muxed by the top; unmapped addresses answer SLVERR
`timescale 1ns/1ps
module beg_axil_slave
  import beg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [BEG_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  beg_wr_if.src wr
);
  logic aw_held_q;
  logic w_held_q;
  logic [BEG_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic fire;
  logic hit_ext;
  logic hit_xtr;
  beg_chan_t st_q;

  // ----------------------------------------------------------------
  // Address and data capture, in either order
  // ----------------------------------------------------------------
  // Ready is a registered one-cycle accept so the top port comes from a flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b0;
    end else begin
      awready <= awvalid && !awready && !aw_held_q && (st_q == BEG_IDLE) && !fire;
    end
  end

  // Same accept pulse for write data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
    end else begin
      wready <= wvalid && !wready && !w_held_q && (st_q == BEG_IDLE) && !fire;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (fire) begin
      aw_held_q <= 1'b0;
    end else if (awvalid && awready) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (fire) begin
      w_held_q <= 1'b0;
    end else if (wvalid && wready) begin
      w_held_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  // One cycle after both halves are held the write takes effect
  assign fire = aw_held_q && w_held_q;
  assign hit_ext = (aw_addr_q[BEG_ADDR_W-1:2] == BEG_OFF_EXT[BEG_ADDR_W-1:2]);
  assign hit_xtr = (aw_addr_q[BEG_ADDR_W-1:2] == BEG_OFF_XTR[BEG_ADDR_W-1:2]);
  assign wr.wr_ext = fire && hit_ext;
  assign wr.wr_xtr = fire && hit_xtr;
  assign wr.wdata = w_data_q;
  assign wr.wstrb = w_strb_q;

  // ----------------------------------------------------------------
  // Write response
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= BEG_IDLE;
      bvalid <= 1'b0;
      bresp <= BEG_RESP_OKAY;
    end else begin
      unique case (st_q)
        BEG_IDLE: begin
          if (fire) begin
            st_q <= BEG_RESP;
            bvalid <= 1'b1;
            bresp <= (hit_ext || hit_xtr) ? BEG_RESP_OKAY : BEG_RESP_SLVERR;
          end
        end
        BEG_RESP: begin
          if (bready) begin
            st_q <= BEG_IDLE;
            bvalid <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule

// ### hdl/beg_pin_bank.sv
// Purpose: One bank of pins with set/clear controlled values and enables
// Assumes: Write strobe and data come from the bus slave
// Notes:   A set and clear of the same bit in one write leaves the set winning
`timescale 1ns/1ps
module beg_pin_bank
  import beg_pkg::*;
#(
  parameter int unsigned N = 3,
  parameter int unsigned VCLR_LSB = 0,
  parameter int unsigned VSET_LSB = 3,
  parameter int unsigned ECLR_LSB = 6,
  parameter int unsigned ESET_LSB = 9
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [31:0] wdata,
  output logic [N-1:0] val_q,
  output logic [N-1:0] oe_q
);
  logic [N-1:0] vclr;
  logic [N-1:0] vset;
  logic [N-1:0] eclr;
  logic [N-1:0] eset;

  assign vclr = wdata[VCLR_LSB +: N];
  assign vset = wdata[VSET_LSB +: N];
  assign eclr = wdata[ECLR_LSB +: N];
  assign eset = wdata[ESET_LSB +: N];

  // ----------------------------------------------------------------
  // Output values: ones clear or set, zeros keep
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      val_q <= '0;
    end else if (wr_en) begin
      val_q <= (val_q & ~vclr) | vset; // R1 R2 R6 R7
    end
  end

  // Driver enables, same style
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oe_q <= '0; // R9
    end else if (wr_en) begin
      oe_q <= (oe_q & ~eclr) | eset; // R3 R4 R8 R9
    end
  end
endmodule

// ### hdl/beg_gpio_top.sv
// Purpose: Extra general-purpose pin registers of a bus bridge, over AXI4-Lite
// Assumes: Pin inputs are synchronous to aclk; single clock, synchronous reset
// Notes:   Both set and clear fields read back the present state
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// (R1) Ext value clear bits 2:0 drive pins low
// (R2) Ext value set bits 5:3 drive pins high
// (R3) Ext enable clear bits 8:6 disable drivers
// (R4) Ext enable set bits 11:9 enable drivers
// (R5) Pin levels read in 14:12 and 19:16
// (R6) Extra value clear bits 3:0 force low
// (R7) Extra value set bits 7:4 force high
// (R8) Extra enable clear bits 11:8 disable drivers
// (R9) Extra enable set bits 15:12; reset zero
// (R10) Set and clear fields read state; reserved zero
module beg_gpio_top
  import beg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [BEG_ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [BEG_ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [BEG_EXT_N-1:0] ext_pin_in,
  output logic [BEG_EXT_N-1:0] ext_pin_out,
  output logic [BEG_EXT_N-1:0] ext_pin_oe,
  input wire logic [BEG_XTR_N-1:0] xtr_in,
  output logic [BEG_XTR_N-1:0] xtr_out,
  output logic [BEG_XTR_N-1:0] xtr_oe
);
  beg_wr_if wr ();
  logic aw_rdy;
  logic w_rdy;
  logic ar_rdy_q;
  logic [BEG_EXT_N-1:0] ext_in_q;
  logic [BEG_XTR_N-1:0] xtr_in_q;
  logic [31:0] rd_word;
  logic rd_hit;

  // ----------------------------------------------------------------
  // Write path
  // ----------------------------------------------------------------
  beg_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axil_awaddr),
    .awvalid(s_axil_awvalid),
    .awready(aw_rdy),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(w_rdy),
    .bresp(s_axil_bresp),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .wr(wr)
  );

  // The slave registers its accept pulses, so they pass straight out
  assign s_axil_awready = aw_rdy;
  assign s_axil_wready = w_rdy;

  // ----------------------------------------------------------------
  // Pin banks
  // ----------------------------------------------------------------
  beg_pin_bank #(
    .N(BEG_EXT_N),
    .VCLR_LSB(BEG_EXT_VCLR_LSB),
    .VSET_LSB(BEG_EXT_VSET_LSB),
    .ECLR_LSB(BEG_EXT_ECLR_LSB),
    .ESET_LSB(BEG_EXT_ESET_LSB)
  ) u_ext (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr.wr_ext),
    .wdata(wr.wdata),
    .val_q(ext_pin_out),
    .oe_q(ext_pin_oe)
  );

  beg_pin_bank #(
    .N(BEG_XTR_N),
    .VCLR_LSB(BEG_XTR_VCLR_LSB),
    .VSET_LSB(BEG_XTR_VSET_LSB),
    .ECLR_LSB(BEG_XTR_ECLR_LSB),
    .ESET_LSB(BEG_XTR_ESET_LSB)
  ) u_xtr (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(wr.wr_xtr),
    .wdata(wr.wdata),
    .val_q(xtr_out),
    .oe_q(xtr_oe)
  );

  // ----------------------------------------------------------------
  // Input sampling
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_in_q <= '0;
      xtr_in_q <= '0;
    end else begin
      ext_in_q <= ext_pin_in; // R5
      xtr_in_q <= xtr_in; // R5
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = BEG_RESET_WORD;
    rd_hit = 1'b0;
    if (s_axil_araddr[BEG_ADDR_W-1:2] == BEG_OFF_EXT[BEG_ADDR_W-1:2]) begin
      rd_hit = 1'b1;
      rd_word[BEG_EXT_VCLR_LSB +: BEG_EXT_N] = ext_pin_out; // R10
      rd_word[BEG_EXT_VSET_LSB +: BEG_EXT_N] = ext_pin_out; // R10
      rd_word[BEG_EXT_ECLR_LSB +: BEG_EXT_N] = ext_pin_oe; // R10
      rd_word[BEG_EXT_ESET_LSB +: BEG_EXT_N] = ext_pin_oe; // R10
      rd_word[BEG_EXT_IN_LSB +: BEG_EXT_N] = ext_in_q; // R5
    end else if (s_axil_araddr[BEG_ADDR_W-1:2] == BEG_OFF_XTR[BEG_ADDR_W-1:2]) begin
      rd_hit = 1'b1;
      rd_word[BEG_XTR_VCLR_LSB +: BEG_XTR_N] = xtr_out; // R10
      rd_word[BEG_XTR_VSET_LSB +: BEG_XTR_N] = xtr_out; // R10
      rd_word[BEG_XTR_ECLR_LSB +: BEG_XTR_N] = xtr_oe; // R10
      rd_word[BEG_XTR_ESET_LSB +: BEG_XTR_N] = xtr_oe; // R10
      rd_word[BEG_XTR_IN_LSB +: BEG_XTR_N] = xtr_in_q; // R5
    end
  end

  // Read channel: arready is a one-cycle pulse, data follows one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b0;
      s_axil_rdata <= '0;
      s_axil_rresp <= BEG_RESP_OKAY;
    end else if (s_axil_rvalid) begin
      s_axil_arready <= 1'b0;
      if (s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end else if (s_axil_arvalid && !s_axil_arready) begin
      s_axil_arready <= 1'b1;
    end else if (s_axil_arvalid && s_axil_arready) begin
      s_axil_arready <= 1'b0;
      s_axil_rvalid <= 1'b1;
      s_axil_rdata <= rd_word;
      s_axil_rresp <= rd_hit ? BEG_RESP_OKAY : BEG_RESP_SLVERR;
    end else begin
      s_axil_arready <= 1'b0;
    end
  end
endmodule

// ### tb/beg_gpio_monitor.sv
// Purpose: Port checks of the extra pin register block
// Assumes: One clock, synchronous active-low reset
// Notes:   A pin change must follow a cycle with wvalid high by at most three cycles
`timescale 1ns/1ps
module beg_gpio_monitor
  import beg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic s_axil_wvalid,
  input wire logic s_axil_wready,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [BEG_EXT_N-1:0] ext_pin_out,
  input wire logic [BEG_EXT_N-1:0] ext_pin_oe,
  input wire logic [BEG_XTR_N-1:0] xtr_out,
  input wire logic [BEG_XTR_N-1:0] xtr_oe
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wbeat;
    s_axil_wvalid && s_axil_wready;
  endsequence
  // Pins may only move if wvalid was high in one of the three previous cycles
  sequence s_wseen;
    $past(s_axil_wvalid) || $past(s_axil_wvalid, 2) || $past(s_axil_wvalid, 3);
  endsequence
  a_reset_clean: assert property ($rose(aresetn) |-> {ext_pin_out, ext_pin_oe, xtr_out, xtr_oe} == '0)
    else $error("pins not zero after reset");
  a_ext_val_cause: assert property ($changed(ext_pin_out) |-> s_wseen)
    else $error("ext value moved without write");
  a_ext_oe_cause: assert property ($changed(ext_pin_oe) |-> s_wseen)
    else $error("ext enable moved without write");
  a_xtr_val_cause: assert property ($changed(xtr_out) |-> s_wseen)
    else $error("extra value moved without write");
  a_xtr_oe_cause: assert property ($changed(xtr_oe) |-> s_wseen)
    else $error("extra enable moved without write");
  a_aw_taken: assert property (s_axil_awvalid |-> ##[0:16] s_axil_awready)
    else $error("write address never taken");
  a_w_answer: assert property (s_wbeat |-> ##[0:8] s_axil_bvalid)
    else $error("write response missing");
  a_r_answer: assert property (s_axil_arvalid && s_axil_arready |-> ##[1:8] s_axil_rvalid)
    else $error("read data missing");
  a_r_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data not held");
endmodule

bind beg_gpio_top beg_gpio_monitor mon (.*);

// ### tb/beg_board_model.sv
// Purpose: Board side of the pins
// Assumes: The board drives a shared pin only while the device does not
// Notes:   Levels come from the bench so reads can be predicted
`timescale 1ns/1ps
module beg_board_model
  import beg_pkg::*;
(
  input wire logic [BEG_EXT_N-1:0] ext_pin_out,
  input wire logic [BEG_EXT_N-1:0] ext_pin_oe,
  input wire logic [BEG_EXT_N-1:0] ext_drive,
  input wire logic [BEG_XTR_N-1:0] xtr_drive,
  output logic [BEG_EXT_N-1:0] ext_pin_in,
  output logic [BEG_XTR_N-1:0] xtr_in
);
  // Shared pin shows the device driver where enabled, else the board level
  assign ext_pin_in = (ext_pin_oe & ext_pin_out) | (~ext_pin_oe & ext_drive);
  assign xtr_in = xtr_drive;
endmodule

// ### tb/testbench.sv
// Purpose: Self-checking bench of the extra pin registers
// Assumes: Set wins over clear in one write; unmapped gives SLVERR
// Notes:   Seeded random writes follow the corner words
`timescale 1ns/1ps
module testbench;
  import beg_pkg::*;
  logic aclk, aresetn, s_axil_awvalid, s_axil_awready, s_axil_wvalid, s_axil_wready;
  logic s_axil_bvalid, s_axil_bready, s_axil_arvalid, s_axil_arready, s_axil_rvalid;
  logic s_axil_rready;
  logic [BEG_ADDR_W-1:0] s_axil_awaddr, s_axil_araddr;
  logic [31:0] s_axil_wdata, s_axil_rdata;
  logic [3:0] s_axil_wstrb;
  logic [1:0] s_axil_bresp, s_axil_rresp;
  logic [BEG_EXT_N-1:0] ext_pin_in, ext_pin_out, ext_pin_oe, ext_drv, ev_q, eo_q;
  logic [BEG_XTR_N-1:0] xtr_in, xtr_out, xtr_oe, xtr_drv, xv_q, xo_q;
  logic [31:0] ext_cw[5] = '{32'h0000_0E38, 32'h0, 32'h0000_01C7, 32'hFFFF_FFFF, 32'h0000_01C7};
  logic [31:0] xtr_cw[5] = '{32'h0000_F0F0, 32'h0, 32'h0000_0F0F, 32'hFFFF_FFFF, 32'h0000_0F0F};
  int error_cnt, tests_run, seed, i;

  beg_gpio_top dut (.*);
  beg_board_model board (.ext_pin_out(ext_pin_out), .ext_pin_oe(ext_pin_oe),
    .ext_drive(ext_drv), .xtr_drive(xtr_drv), .ext_pin_in(ext_pin_in), .xtr_in(xtr_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----
  // Checking and bus tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    tests_run++;
    if (got !== ex) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A bus wait that runs out ends the run rather than hanging
  task automatic hang(input int n);
    if (n >= 80) begin
      chk("bus answer", 32'h1, 32'h0);
      end_of_test();
    end
  endtask

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    s_axil_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awready === 1'b1) s_axil_awvalid <= 1'b0;
      if (s_axil_wready === 1'b1) s_axil_wvalid <= 1'b0;
      n++;
    end while (s_axil_bvalid !== 1'b1 && n < 80);
    hang(n);
    s_axil_bready <= 1'b0;
    chk("bresp", er, s_axil_bresp);
    @(posedge aclk);
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
    int n;
    n = 0;
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    s_axil_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arready === 1'b1) s_axil_arvalid <= 1'b0;
      n++;
    end while (s_axil_rvalid !== 1'b1 && n < 80);
    hang(n);
    s_axil_rready <= 1'b0;
    chk("rresp", er, s_axil_rresp);
    if (er == BEG_RESP_OKAY) chk("rdata", ex, s_axil_rdata);
    @(posedge aclk);
  endtask

  // Expected words: set and clear fields both show state, pin levels above
  function automatic logic [31:0] ext_word();
    logic [2:0] p;
    p = (eo_q & ev_q) | (~eo_q & ext_drv);
    return {17'h0, p, eo_q, eo_q, ev_q, ev_q};
  endfunction

  task automatic chkall();
    repeat (3) @(posedge aclk);
    chk("ext_pin_out", 32'(ev_q), 32'(ext_pin_out));
    chk("ext_pin_oe", 32'(eo_q), 32'(ext_pin_oe));
    chk("xtr_out", 32'(xv_q), 32'(xtr_out));
    chk("xtr_oe", 32'(xo_q), 32'(xtr_oe));
    axr(BEG_OFF_EXT, ext_word(), BEG_RESP_OKAY);
    axr(BEG_OFF_XTR, {12'h0, xtr_drv, xo_q, xo_q, xv_q, xv_q}, BEG_RESP_OKAY);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    axw(a, d, BEG_RESP_OKAY);
    if (a == BEG_OFF_EXT) begin
      ev_q = (ev_q & ~d[2:0]) | d[5:3];
      eo_q = (eo_q & ~d[8:6]) | d[11:9];
    end else begin
      xv_q = (xv_q & ~d[3:0]) | d[7:4];
      xo_q = (xo_q & ~d[11:8]) | d[15:12];
    end
    chkall();
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    seed = 40;
    error_cnt = 0;
    tests_run = 0;
    aresetn = 1'b0;
    {s_axil_awvalid, s_axil_wvalid, s_axil_bready, s_axil_arvalid, s_axil_rready} = '0;
    {s_axil_awaddr, s_axil_araddr, s_axil_wdata} = '0;
    s_axil_wstrb = 4'hF;
    {ev_q, eo_q, xv_q, xo_q} = '0;
    ext_drv = 3'h5;
    xtr_drv = 4'hA;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    chkall();
    $display("reset values done");
    for (i = 0; i < 5; i++) begin
      wr(BEG_OFF_EXT, ext_cw[i]);
      wr(BEG_OFF_XTR, xtr_cw[i]);
    end
    $display("corner words done");
    for (i = 0; i < 40; i++) begin
      ext_drv <= 3'($random(seed));
      xtr_drv <= 4'($random(seed));
      wr(i[0] ? BEG_OFF_XTR : BEG_OFF_EXT, $random(seed));
    end
    $display("random writes done");
    // A write to an unmapped word must leave every pin alone
    axw(12'h308, 32'hFFFF_FFFF, BEG_RESP_SLVERR);
    chkall();
    axr(12'h308, 32'h0, BEG_RESP_SLVERR);
    $display("unmapped access done");
    wr(BEG_OFF_EXT, 32'h0000_0E38);
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    {ev_q, eo_q, xv_q, xo_q} = '0;
    chkall();
    $display("second reset done");
    end_of_test();
  end
endmodule
